// file: rtl/mwp_ctrl.sv
// window page device and power override registers behind an axi4-lite slave
//
// Contract
// [R1] index 72h holds set a pages 7-4 types
// [R2] type codes: rom, main, reserved, bios
// [R3] index 73h holds set b pages 3-0
// [R4] set select routes shared page io
// [R5] set b enable gates all set b windows
// [R6] battery low 4 suspends unless suppressed; the code also blocks it while ac_adapter_present is high
// [R7] battery low 2 sleeps unless suppressed; the code also blocks it while ac_adapter_present is high
// [R8] sleep suppress leaves smi and status alone
// [R9] doze clock runs while irq0 high
// [R10] clock kept 64 refreshes after irq0
// [R11] direction bit makes gp pin output
// [R12] index 71h holds set a pages 3-0
// [R13] software writes zero to reserved bits
// [R14] registers reset to zero, read back
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "mwp_params.svh"

module mwp_ctrl
	import mwp_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	input  wire logic [`MWP_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [`MWP_AXI_AW-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  io_page_cycle,
	output logic                       io_to_set_a,
	output logic                       io_to_set_b,
	input  wire logic [3:0]            b_page_bit7,
	output logic [3:0]                 b_window_enable,
	output mwp_asel_s                  a_sel,
	output mwp_bsel_s                  b_sel,
	input  wire logic                  battery_low_level4_n,
	input  wire logic                  battery_low_level2_n,
	input  wire logic                  ac_adapter_present,
	output logic                       suspend_request,
	output logic                       sleep_request,
	output logic                       bl2_smi_request,
	input  wire logic                  pm_doze,
	input  wire logic                  irq0,
	input  wire logic                  refresh_tick,
	output logic                       cpu_clock_keep,
	input  wire logic                  gp_pin1_in,
	output logic                       gp_pin1_out,
	output logic                       gp_pin1_oe
);

	// ============================================================
	// declarations
	logic [7:0]            reg_a_lo;
	logic [7:0]            reg_a_hi;
	logic [7:0]            reg_b;
	mwp_ctl_s              ctl;
	logic                  pmc_extend;
	logic                  gp_data;
	logic [7:0]            next_a_lo;
	logic [7:0]            next_a_hi;
	logic [7:0]            next_b;
	mwp_ctl_s              next_ctl;
	logic                  next_extend;
	logic                  next_gp_data;

	logic                  aw_held;
	logic                  w_held;
	logic [7:0]            aw_idx;
	logic                  aw_ok;
	logic [7:0]            w_byte;
	logic                  w_lane0;
	logic                  next_aw_held;
	logic                  next_w_held;
	logic [7:0]            next_aw_idx;
	logic                  next_aw_ok;
	logic [7:0]            next_w_byte;
	logic                  next_w_lane0;
	logic                  next_awready;
	logic                  next_wready;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  next_arready;
	logic                  next_rvalid;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;
	logic                  commit;

	logic [3:0]            pin_raw;
	logic [3:0]            sy1;
	logic [3:0]            sy2;
	logic [3:0]            sy3;
	logic [3:0]            pin_st;
	logic [3:0]            pin_prev;
	logic [3:0]            next_pin_st;

	logic                  next_io_a;
	logic                  next_io_b;
	logic [3:0]            next_b_en;
	mwp_asel_s             next_a_sel;
	mwp_bsel_s             next_b_sel;
	logic                  next_susp;
	logic                  next_sleep;
	logic                  next_smi;
	logic                  bl4_fall;
	logic                  bl2_fall;
	logic [15:0]           a_types;

	// ============================================================
	// write path: address and data are held until both arrive
	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_idx  = aw_idx;
		next_aw_ok   = aw_ok;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		commit       = aw_held && w_held && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_idx  = s_axi_awaddr[9:2];
			next_aw_ok   = (s_axi_awaddr[11:10] == 2'h0) && (s_axi_awaddr[1:0] == 2'h0);
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held  = 1'b1;
			next_w_byte  = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (commit)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_ok && idx_mapped(aw_idx)) ? `MWP_RESP_OKAY : `MWP_RESP_SLVERR;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_idx        <= 8'h00;
			aw_ok         <= 1'b0;
			w_byte        <= 8'h00;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `MWP_RESP_OKAY;
		end
		else if (ce)
		begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_idx        <= next_aw_idx;
			aw_ok         <= next_aw_ok;
			w_byte        <= next_w_byte;
			w_lane0       <= next_w_lane0;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
		end
	end

	// ============================================================
	// address decode helper
	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx == `MWP_IDX_A_LO) || (idx == `MWP_IDX_A_HI) ||
		             (idx == `MWP_IDX_B) || (idx == `MWP_IDX_CTRL) ||
		             (idx == `MWP_IDX_STATUS) || (idx == `MWP_IDX_PMC) ||
		             (idx == `MWP_IDX_GPIO);
	endfunction

	// ============================================================
	// register file; only byte lane 0 carries data
	always_comb
	begin
		next_a_lo    = reg_a_lo;
		next_a_hi    = reg_a_hi;
		next_b       = reg_b;
		next_ctl     = ctl;
		next_extend  = pmc_extend;
		next_gp_data = gp_data;
		if (commit && aw_ok && w_lane0)
		begin
			unique case (aw_idx)
				// [R12] set a low pages
				`MWP_IDX_A_LO: next_a_lo = w_byte;
				// [R1] set a high pages
				`MWP_IDX_A_HI: next_a_hi = w_byte;
				// [R3] set b pages
				`MWP_IDX_B:    next_b    = w_byte;
				// [R14] plain read-write storage; reserved bits kept as written
				`MWP_IDX_CTRL: next_ctl  = mwp_ctl_s'(w_byte);
				`MWP_IDX_PMC:  next_extend  = w_byte[0];
				`MWP_IDX_GPIO: next_gp_data = w_byte[0];
				default:       next_a_lo = reg_a_lo;
			endcase
		end
	end

	// [R14] all registers clear on reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			reg_a_lo   <= `MWP_REG_RESET;
			reg_a_hi   <= `MWP_REG_RESET;
			reg_b      <= `MWP_REG_RESET;
			ctl        <= mwp_ctl_s'(`MWP_REG_RESET);
			pmc_extend <= 1'b0;
			gp_data    <= 1'b0;
		end
		else if (ce)
		begin
			reg_a_lo   <= next_a_lo;
			reg_a_hi   <= next_a_hi;
			reg_b      <= next_b;
			ctl        <= next_ctl;
			pmc_extend <= next_extend;
			gp_data    <= next_gp_data;
		end
	end

	// ============================================================
	// read path: one read at a time, data one cycle after the address
	always_comb
	begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rdata  = 32'h0000_0000;
			next_rresp  = `MWP_RESP_OKAY;
			if ((s_axi_araddr[11:10] != 2'h0) || (s_axi_araddr[1:0] != 2'h0))
				next_rresp = `MWP_RESP_SLVERR;
			else
			begin
				unique case (s_axi_araddr[9:2])
					`MWP_IDX_A_LO:   next_rdata[7:0] = reg_a_lo;
					`MWP_IDX_A_HI:   next_rdata[7:0] = reg_a_hi;
					`MWP_IDX_B:      next_rdata[7:0] = reg_b;
					`MWP_IDX_CTRL:   next_rdata[7:0] = ctl;
					// [R8] battery status independent of suppress bits
					`MWP_IDX_STATUS: next_rdata[3:0] = {pin_st[3], pin_st[2], !pin_st[0], !pin_st[1]};
					`MWP_IDX_PMC:    next_rdata[0]   = pmc_extend;
					`MWP_IDX_GPIO:   next_rdata[1:0] = {pin_st[3], gp_data};
					default:         next_rresp      = `MWP_RESP_SLVERR;
				endcase
			end
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `MWP_RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ============================================================
	// pin synchronisers: three flops, a change counts when stages two and three agree
	assign pin_raw = {gp_pin1_in, ac_adapter_present, battery_low_level2_n, battery_low_level4_n};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			assign next_pin_st[gi] = (sy2[gi] == sy3[gi]) ? sy3[gi] : pin_st[gi];
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sy1      <= 4'h3;
			sy2      <= 4'h3;
			sy3      <= 4'h3;
			pin_st   <= 4'h3;
			pin_prev <= 4'h3;
		end
		else if (ce)
		begin
			sy1      <= pin_raw;
			sy2      <= sy1;
			sy3      <= sy2;
			pin_st   <= next_pin_st;
			pin_prev <= pin_st;
		end
	end

	// ============================================================
	// battery low requests to the power manager
	assign bl4_fall = pin_prev[0] && !pin_st[0];
	assign bl2_fall = pin_prev[1] && !pin_st[1];

	always_comb
	begin
		// [R6] suspend on battery low 4
		next_susp  = bl4_fall && !ctl.suspend_suppress && !pin_st[2];
		// [R7] sleep on battery low 2
		next_sleep = bl2_fall && !ctl.sleep_suppress && !pin_st[2];
		// [R8] smi ignores sleep suppress
		next_smi   = bl2_fall;
	end

	// ============================================================
	// page device decode, io routing and set b gating
	assign a_types = {reg_a_hi, reg_a_lo};

	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_adec
			// [R2] decode set a types
			assign next_a_sel.rom[gi]  = a_types[2*gi+:2] == `MWP_DEV_ROM;
			assign next_a_sel.main[gi] = a_types[2*gi+:2] == `MWP_DEV_MAIN;
			assign next_a_sel.bios[gi] = a_types[2*gi+:2] == `MWP_DEV_BIOS;
		end
		for (gi = 0; gi < 4; gi++)
		begin : g_bdec
			// [R2] decode set b types
			assign next_b_sel.rom[gi]  = reg_b[2*gi+:2] == `MWP_DEV_ROM;
			assign next_b_sel.main[gi] = reg_b[2*gi+:2] == `MWP_DEV_MAIN;
			assign next_b_sel.bios[gi] = reg_b[2*gi+:2] == `MWP_DEV_BIOS;
			// [R5] master enable and page bit 7
			assign next_b_en[gi] = ctl.window_b_enable && b_page_bit7[gi];
		end
	endgenerate

	always_comb
	begin
		// [R4] route shared io cycles
		next_io_a = io_page_cycle && ctl.window_set_select;
		next_io_b = io_page_cycle && !ctl.window_set_select;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			io_to_set_a     <= 1'b0;
			io_to_set_b     <= 1'b0;
			b_window_enable <= 4'h0;
			a_sel           <= '0;
			b_sel           <= '0;
			suspend_request <= 1'b0;
			sleep_request   <= 1'b0;
			bl2_smi_request <= 1'b0;
			gp_pin1_out     <= 1'b0;
			gp_pin1_oe      <= 1'b0;
		end
		else if (ce)
		begin
			io_to_set_a     <= next_io_a;
			io_to_set_b     <= next_io_b;
			b_window_enable <= next_b_en;
			a_sel           <= next_a_sel;
			b_sel           <= next_b_sel;
			suspend_request <= next_susp;
			sleep_request   <= next_sleep;
			bl2_smi_request <= next_smi;
			gp_pin1_out     <= gp_data;
			// [R11] direction drives pin enable
			gp_pin1_oe      <= ctl.gp_pin1_direction;
		end
	end

	// ============================================================
	// doze clock keep-alive
	// [R9] irq0 keeps doze clock
	mwp_cpu_clock_out_hold u_hold (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.ce           (ce),
		.doze         (pm_doze),
		.irq0         (irq0),
		.refresh_tick (refresh_tick),
		.enable       (ctl.doze_timer_irq_enable),
		.extend       (pmc_extend),
		.keep         (cpu_clock_keep)
	);

endmodule
`default_nettype wire

// file: rtl/mwp_params.svh
// register map, field positions, encodings and counts of the window page control block
`ifndef MWP_PARAMS_SVH
`define MWP_PARAMS_SVH

// ============================================================
// register indexes (byte address is four times the index)
`define MWP_IDX_A_LO     8'h71
`define MWP_IDX_A_HI     8'h72
`define MWP_IDX_B        8'h73
`define MWP_IDX_CTRL     8'h74
`define MWP_IDX_STATUS   8'hA3
`define MWP_IDX_PMC      8'hAF
`define MWP_IDX_GPIO     8'hF0

// ============================================================
// bus geometry and answers
`define MWP_AXI_AW       12
`define MWP_RESP_OKAY    2'h0
`define MWP_RESP_SLVERR  2'h2
`define MWP_REG_RESET    8'h00

// ============================================================
// control register field positions
`define MWP_CTL_SUSP     7
`define MWP_CTL_SLEEP    6
`define MWP_CTL_DOZE     3
`define MWP_CTL_GPDIR    2
`define MWP_CTL_SETSEL   1
`define MWP_CTL_BEN      0
`define MWP_CTL_MUSTZERO 8'h30

// ============================================================
// page device type codes
`define MWP_DEV_ROM      2'h0
`define MWP_DEV_MAIN     2'h1
`define MWP_DEV_RSVD     2'h2
`define MWP_DEV_BIOS     2'h3

// ============================================================
// clock keep-alive after the timer interrupt drops
`define MWP_KEEP_REFRESH 7'h40
`define MWP_CNT_W        7

`endif

// file: rtl/mwp_pkg.sv
// types shared by the window page control block
package mwp_pkg;

	// decoded device selects for the eight pages of set a
	typedef struct packed {
		logic [7:0] rom;
		logic [7:0] main;
		logic [7:0] bios;
	} mwp_asel_s;

	// decoded device selects for the four pages of set b
	typedef struct packed {
		logic [3:0] rom;
		logic [3:0] main;
		logic [3:0] bios;
	} mwp_bsel_s;

	// control register layout
	typedef struct packed {
		logic       suspend_suppress;
		logic       sleep_suppress;
		logic [1:0] must_zero;
		logic       doze_timer_irq_enable;
		logic       gp_pin1_direction;
		logic       window_set_select;
		logic       window_b_enable;
	} mwp_ctl_s;

endpackage

// file: rtl/mwp_cpu_clock_out_hold.sv
// cpu clock keep-alive in doze while the timer interrupt is active
`timescale 1ns/10ps
`default_nettype none
`include "mwp_params.svh"

module mwp_cpu_clock_out_hold
	import mwp_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	input  wire logic doze,
	input  wire logic irq0,
	input  wire logic refresh_tick,
	input  wire logic enable,
	input  wire logic extend,
	output logic      keep
);

	logic [`MWP_CNT_W-1:0] cnt;
	logic [`MWP_CNT_W-1:0] next_cnt;
	logic                  next_keep;

	// ============================================================
	// refresh countdown and keep-alive decision
	always_comb
	begin
		next_cnt = cnt;
		// [R10] reload while irq0 high
		if (irq0 && extend)
			next_cnt = `MWP_KEEP_REFRESH;
		else if (!extend)
			next_cnt = '0;
		else if (refresh_tick && (cnt != '0))
			next_cnt = cnt - 1'b1;
		// [R9] run while irq0 high
		next_keep = doze && enable && (irq0 || (extend && (cnt != '0)));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt  <= '0;
			keep <= 1'b0;
		end
		else if (ce)
		begin
			cnt  <= next_cnt;
			keep <= next_keep;
		end
	end

endmodule
`default_nettype wire

// file: dv/mwp_ctrl_props.sv
// assertion checker for the window page control block
`timescale 1ns/10ps
`default_nettype none

module mwp_ctrl_props
	import mwp_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        io_page_cycle,
	input wire logic        io_to_set_a,
	input wire logic        io_to_set_b,
	input wire logic [3:0]  b_page_bit7,
	input wire logic [3:0]  b_window_enable,
	input wire mwp_asel_s   a_sel,
	input wire mwp_bsel_s   b_sel,
	input wire logic        ac_adapter_present,
	input wire logic        suspend_request,
	input wire logic        sleep_request,
	input wire logic        pm_doze,
	input wire logic        irq0,
	input wire logic        refresh_tick,
	input wire logic        cpu_clock_keep
);
	// ============================================================
	// refresh ticks counted since the timer interrupt dropped
	logic [7:0] ticks;
	logic [7:0] next_ticks;

	// count saturates so a long doze cannot wrap it
	always_comb
	begin
		next_ticks = ticks;
		if (irq0)
			next_ticks = 8'h00;
		else if (refresh_tick && ticks != 8'hFF)
			next_ticks = ticks + 8'h01;
	end

	// register the tick count
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ticks <= 8'h00;
		else
			ticks <= next_ticks;
	end

	// ============================================================
	// properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_IO_ROUTE: assert property ((io_to_set_a | io_to_set_b) == $past(io_page_cycle) && !(io_to_set_a & io_to_set_b))
		else $error("page io routing wrong");
	AST_BWIN_GATE: assert property ((b_window_enable & ~$past(b_page_bit7)) == 4'h0)
		else $error("set b window enabled without page bit");
	AST_ASEL_ONE: assert property (((a_sel.rom & a_sel.main) | (a_sel.rom & a_sel.bios) | (a_sel.main & a_sel.bios)) == 8'h00)
		else $error("set a page selects two devices");
	AST_BSEL_ONE: assert property (((b_sel.rom & b_sel.main) | (b_sel.rom & b_sel.bios) | (b_sel.main & b_sel.bios)) == 4'h0)
		else $error("set b page selects two devices");
	AST_AC_BLOCKS: assert property (ac_adapter_present [*8] |-> !suspend_request && !sleep_request)
		else $error("transition requested on adapter power");
	AST_SLEEP_PULSE: assert property (sleep_request |=> !sleep_request)
		else $error("sleep request longer than one cycle");
	AST_SUSP_PULSE: assert property ($rose(suspend_request) |=> $fell(suspend_request))
		else $error("suspend request longer than one cycle");
	AST_KEEP_DOZE: assert property (cpu_clock_keep |-> $past(pm_doze))
		else $error("clock kept outside doze");
	AST_KEEP_COUNT: assert property (cpu_clock_keep |-> ticks <= 8'h40)
		else $error("clock kept past refresh count");
	AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
		else $error("read answer late or upper bits set");
endmodule

bind mwp_ctrl mwp_ctrl_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .io_page_cycle,
	.io_to_set_a, .io_to_set_b, .b_page_bit7, .b_window_enable, .a_sel, .b_sel, .ac_adapter_present,
	.suspend_request, .sleep_request, .pm_doze, .irq0, .refresh_tick, .cpu_clock_keep);
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the window page control block
`timescale 1ns/10ps
`default_nettype none
`include "mwp_params.svh"

module tb_top
	import mwp_pkg::*;
;
	// ============================================================
	// stimulus and observed signals
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        ce = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        io_page_cycle = 1'b0;
	logic [3:0]  b_page_bit7 = 4'h0;
	logic        battery_low_level4_n = 1'b1;
	logic        battery_low_level2_n = 1'b1;
	logic        ac_adapter_present = 1'b0;
	logic        pm_doze = 1'b0;
	logic        irq0 = 1'b0;
	logic        refresh_tick = 1'b0;
	logic        gp_pin1_in = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        io_to_set_a, io_to_set_b, suspend_request, sleep_request, bl2_smi_request;
	logic        cpu_clock_keep, gp_pin1_out, gp_pin1_oe;
	logic [3:0]  b_window_enable;
	mwp_asel_s   a_sel;
	mwp_bsel_s   b_sel;
	int          num_errors = 0;
	int          check_count = 0;

	always #5 aclk = ~aclk;

	mwp_ctrl i_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .io_page_cycle, .io_to_set_a, .io_to_set_b, .b_page_bit7, .b_window_enable, .a_sel, .b_sel,
		.battery_low_level4_n, .battery_low_level2_n, .ac_adapter_present, .suspend_request, .sleep_request,
		.bl2_smi_request, .pm_doze, .irq0, .refresh_tick, .cpu_clock_keep, .gp_pin1_in, .gp_pin1_out, .gp_pin1_oe);

	// ============================================================
	// shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction

	// device selects of four pages, rom then main then bios
	function automatic logic [11:0] dec(input logic [7:0] v);
		logic [3:0] r, m, b;
		for (int p = 0; p < 4; p++)
		begin
			r[p] = v[2*p +: 2] == `MWP_DEV_ROM;
			m[p] = v[2*p +: 2] == `MWP_DEV_MAIN;
			b[p] = v[2*p +: 2] == `MWP_DEV_BIOS;
		end
		return {r, m, b};
	endfunction

	// one write, valids dropped as each channel is taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw, w, got;
		logic [1:0] r;
		int n;
		aw = 1'b1;
		w = 1'b1;
		got = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!got && n < 100)
		begin
			@(negedge aclk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			got = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
			n++;
		end
		s_axi_bready <= 1'b0;
		@(posedge aclk);
		chk(r, er);
	endtask

	// one read, data and response judged
	task automatic rd(input logic [11:0] a, input logic [7:0] ed, input logic [1:0] er);
		logic ar, got;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		ar = 1'b1;
		got = 1'b0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!got && n < 100)
		begin
			@(negedge aclk);
			ar = ar && !s_axi_arready;
			got = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			s_axi_arvalid <= ar;
			n++;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		chk(d, {24'h000000, ed});
		chk(r, er);
	endtask

	// ============================================================
	// scenarios
	// reset values
	task automatic t_reset();
		cyc(2);
		chk(a_sel, {8'hFF, 16'h0000});
		chk(b_sel, {4'hF, 8'h00});
		rd(ad(`MWP_IDX_A_LO), 8'h00, `MWP_RESP_OKAY);
		rd(ad(`MWP_IDX_A_HI), 8'h00, `MWP_RESP_OKAY);
		rd(ad(`MWP_IDX_B), 8'h00, `MWP_RESP_OKAY);
		rd(ad(`MWP_IDX_CTRL), 8'h00, `MWP_RESP_OKAY);
	endtask

	task automatic t_types();
		logic [7:0] v[4] = '{8'h1F, 8'h7C, 8'hF1, 8'hC7};
		logic [11:0] lo, hi, bb;
		for (int i = 0; i < 4; i++)
		begin
			wr(ad(`MWP_IDX_A_LO), v[i], `MWP_RESP_OKAY);
			wr(ad(`MWP_IDX_A_HI), v[(i + 1) % 4], `MWP_RESP_OKAY);
			wr(ad(`MWP_IDX_B), v[(i + 2) % 4], `MWP_RESP_OKAY);
			cyc(2);
			lo = dec(v[i]);
			hi = dec(v[(i + 1) % 4]);
			bb = dec(v[(i + 2) % 4]);
			chk(a_sel, {hi[11:8], lo[11:8], hi[7:4], lo[7:4], hi[3:0], lo[3:0]});
			chk(b_sel, bb);
			rd(ad(`MWP_IDX_A_HI), v[(i + 1) % 4], `MWP_RESP_OKAY);
		end
	endtask

	task automatic t_ctrl();
		logic [7:0] v[4] = '{8'h00, 8'h07, 8'h02, 8'h05};
		b_page_bit7 <= 4'hA;
		io_page_cycle <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wr(ad(`MWP_IDX_CTRL), v[i], `MWP_RESP_OKAY);
			wr(ad(`MWP_IDX_GPIO), v[i], `MWP_RESP_OKAY);
			cyc(2);
			chk(gp_pin1_out, v[i][0]);
			chk(io_to_set_a, v[i][1]);
			chk(io_to_set_b, !v[i][1]);
			chk(b_window_enable, v[i][0] ? 4'hA : 4'h0);
			chk(gp_pin1_oe, v[i][2]);
			rd(ad(`MWP_IDX_CTRL), v[i], `MWP_RESP_OKAY);
		end
		io_page_cycle <= 1'b0;
	endtask

	task automatic t_bad();
		wr(12'h040, 8'h55, `MWP_RESP_SLVERR);
		rd(12'h040, 8'h00, `MWP_RESP_SLVERR);
		wr(ad(`MWP_IDX_A_LO) + 12'h001, 8'h55, `MWP_RESP_SLVERR);
		rd(ad(`MWP_IDX_A_LO), 8'hC7, `MWP_RESP_OKAY);
	endtask

	// battery low handling, seen is suspend, sleep, smi
	task automatic t_batt(input logic four, input logic [7:0] ctl, input logic ac, input logic [2:0] exp);
		logic [2:0] seen;
		seen = 3'h0;
		wr(ad(`MWP_IDX_CTRL), ctl, `MWP_RESP_OKAY);
		ac_adapter_present <= ac;
		cyc(8);
		battery_low_level4_n <= !four;
		battery_low_level2_n <= four;
		repeat (12)
		begin
			@(negedge aclk);
			seen = seen | {suspend_request, sleep_request, bl2_smi_request};
		end
		@(posedge aclk);
		chk(seen, exp);
		rd(ad(`MWP_IDX_STATUS), {5'h00, ac, four, !four}, `MWP_RESP_OKAY);
		battery_low_level4_n <= 1'b1;
		battery_low_level2_n <= 1'b1;
		cyc(10);
	endtask

	task automatic t_keep();
		wr(ad(`MWP_IDX_CTRL), 8'h08, `MWP_RESP_OKAY);
		wr(ad(`MWP_IDX_PMC), 8'h00, `MWP_RESP_OKAY);
		pm_doze <= 1'b1;
		irq0 <= 1'b1;
		cyc(3);
		chk(cpu_clock_keep, 1'b1);
		irq0 <= 1'b0;
		cyc(3);
		chk(cpu_clock_keep, 1'b0);
		wr(ad(`MWP_IDX_PMC), 8'h01, `MWP_RESP_OKAY);
		irq0 <= 1'b1;
		cyc(3);
		irq0 <= 1'b0;
		cyc(3);
		for (int i = 0; i < 64; i++)
		begin
			refresh_tick <= 1'b1;
			cyc(1);
			refresh_tick <= 1'b0;
			cyc(1);
			chk(cpu_clock_keep, 1'b1);
		end
		cyc(2);
		chk(cpu_clock_keep, 1'b0);
		pm_doze <= 1'b0;
	endtask

	// ============================================================
	// main sequence and watchdog
	initial
	begin
		cyc(5);
		aresetn <= 1'b1;
		t_reset();
		t_types();
		t_ctrl();
		t_bad();
		t_batt(1'b0, 8'h00, 1'b0, 3'h3);
		t_batt(1'b0, 8'h40, 1'b0, 3'h1);
		t_batt(1'b1, 8'h00, 1'b0, 3'h4);
		t_batt(1'b1, 8'h80, 1'b0, 3'h0);
		t_batt(1'b1, 8'h00, 1'b1, 3'h0);
		t_batt(1'b0, 8'h00, 1'b1, 3'h1);
		t_keep();
		cyc(5);
		end_of_test();
	end

	initial
	begin
		#200000;
		num_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
